/* logic/spsd_sfr_decode.sv */
// Address decode of the control register space
`timescale 1ns/1ps
`include "spsd_cfg.svh"

module spsd_ctl_decode #(
	parameter logic [127:0] CTL_MAP = `SPSD_CTL_MAP
) (
	input wire logic [7:0] addr,
	input wire logic direct,
	input wire logic bitOp,
	output logic toCtl,
	output logic isStack,
	output logic reserved,
	output logic bitRefused
);
	always_comb begin
		// [RULE7] Direct upper half
		// [RULE12] Indirect never reaches registers
		toCtl = direct && addr[7];
		isStack = toCtl && (addr == `SPSD_PTR_ADDR);
		// [RULE10] Unassigned is reserved
		reserved = toCtl && !CTL_MAP[addr[6:0]];
		// [RULE8] Bit decode on 0x0 and 0x8
		// [RULE9] Byte only elsewhere
		bitRefused = toCtl && bitOp && !reserved &&
			(addr[3:0] != `SPSD_BIT_NIB_A) &&
			(addr[3:0] != `SPSD_BIT_NIB_B);
	end
endmodule

/* logic/spsd_top.sv */
// Stack pointer, internal data memory and control register access routing
`timescale 1ns/1ps
`include "spsd_cfg.svh"

module spsd_top #(
	parameter int DATA_W = `SPSD_DATA_W,
	parameter int MEM_DEPTH = `SPSD_MEM_DEPTH
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic reqValid,
	input wire spsd_pkg::spsd_op_t reqOp,
	input wire logic reqDirect,
	input wire logic [7:0] reqAddr,
	input wire logic [2:0] reqBitPos,
	input wire logic [DATA_W-1:0] reqData,
	input wire logic reqBitVal,
	input wire logic [DATA_W-1:0] ctlRdData,
	output logic busy,
	output logic rspValid,
	output logic [DATA_W-1:0] rspData,
	output logic rspReserved,
	output logic rspRefused,
	output logic ctlStrobe,
	output logic ctlWrite,
	output logic ctlBitOp,
	output logic [7:0] ctlAddr,
	output logic [2:0] ctlBitPos,
	output logic [DATA_W-1:0] ctlWrData,
	output logic [7:0] stack_top_pointer
);
	// Whole 256-byte space is usable as stack or scratch
	logic [DATA_W-1:0] dataMem [0:MEM_DEPTH-1];
	spsd_pkg::spsd_state_t state;
	logic take;
	logic isPush;
	logic isPop;
	logic isBit;
	logic isRead;
	logic isWrite;
	logic toCtl;
	logic isStack;
	logic reserved;
	logic bitRefused;
	logic ctlGo;
	logic ramGo;
	logic [7:0] pushAddr;
	logic [DATA_W-1:0] ramByte;
	logic [DATA_W-1:0] next_rspData;

	function automatic logic [DATA_W-1:0] setBit(
		input logic [DATA_W-1:0] b,
		input logic [2:0] pos,
		input logic val
	);
		logic [DATA_W-1:0] r;
		r = b;
		r[pos] = val;
		return r;
	endfunction

	function automatic logic [DATA_W-1:0] bitByte(
		input logic [DATA_W-1:0] b,
		input logic [2:0] pos
	);
		logic [DATA_W-1:0] r;
		r = '0;
		r[0] = b[pos];
		return r;
	endfunction

	spsd_ctl_decode u_decode (
		.addr(reqAddr),
		.direct(reqDirect),
		.bitOp(isBit),
		.toCtl(toCtl),
		.isStack(isStack),
		.reserved(reserved),
		.bitRefused(bitRefused)
	);

	always_comb begin
		take = reqValid && (state == spsd_pkg::ST_IDLE);
		isPush = take && (reqOp == spsd_pkg::OP_PUSH);
		isPop = take && (reqOp == spsd_pkg::OP_POP);
		isBit = (reqOp == spsd_pkg::OP_BIT_RD) ||
			(reqOp == spsd_pkg::OP_BIT_WR);
		isRead = take && ((reqOp == spsd_pkg::OP_RD) ||
			(reqOp == spsd_pkg::OP_BIT_RD));
		isWrite = take && ((reqOp == spsd_pkg::OP_WR) ||
			(reqOp == spsd_pkg::OP_BIT_WR));
		// [RULE7] Direct upper-half traffic leaves for the registers
		ctlGo = (isRead || isWrite) && toCtl && !isStack &&
			!reserved && !bitRefused;
		// [RULE12] Indirect upper addresses stay in data RAM
		ramGo = (isRead || isWrite) && !toCtl;
		// [RULE3] Push target is one above the current pointer
		pushAddr = stack_top_pointer + `SPSD_PTR_STEP;
		ramByte = dataMem[reqAddr];
	end

	// Memory writes: pushes and plain RAM stores
	always_ff @(posedge clock) begin
		if (isPush) begin
			// [RULE1] Any location the pointer selects
			dataMem[pushAddr] <= reqData;
		end else if (ramGo && isWrite) begin
			if (isBit) begin
				dataMem[reqAddr] <= setBit(ramByte, reqBitPos, reqBitVal);
			end else begin
				dataMem[reqAddr] <= reqData;
			end
		end
	end

	// Stack pointer
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			// [RULE4] Reset value
			stack_top_pointer <= `SPSD_PTR_RESET;
		end else if (isPush) begin
			// [RULE6] Wraps over all 256 bytes, no depth limit
			stack_top_pointer <= pushAddr;
		end else if (isPop) begin
			// [RULE13] Decrement after the read
			stack_top_pointer <= stack_top_pointer - `SPSD_PTR_STEP;
		end else if (isWrite && isStack && !isBit) begin
			// [RULE2] Software may place the pointer
			stack_top_pointer <= reqData;
		end
	end

	// Sequencer: register reads wait one cycle for the peripheral
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= spsd_pkg::ST_IDLE;
			busy <= 1'b0;
		end else begin
			case (state)
				spsd_pkg::ST_IDLE: begin
					if (ctlGo && isRead) begin
						state <= spsd_pkg::ST_CTL_READ;
						busy <= 1'b1;
					end
				end
				spsd_pkg::ST_CTL_READ: begin
					state <= spsd_pkg::ST_IDLE;
					busy <= 1'b0;
				end
				default: begin
					state <= spsd_pkg::ST_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end

	// Register-space strobe and address
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctlStrobe <= 1'b0;
			ctlWrite <= 1'b0;
			ctlBitOp <= 1'b0;
			ctlAddr <= `SPSD_BYTE_ZERO;
			ctlBitPos <= '0;
			ctlWrData <= '0;
		end else begin
			ctlStrobe <= ctlGo;
			ctlWrite <= ctlGo && isWrite;
			if (ctlGo) begin
				// [RULE8] Bit ops pass out only on bit-capable addresses
				ctlBitOp <= isBit;
				ctlAddr <= reqAddr;
				ctlBitPos <= reqBitPos;
				ctlWrData <= isBit ? DATA_W'(reqBitVal) : reqData;
			end
		end
	end

	always_comb begin
		next_rspData = '0;
		if (isPop) begin
			// [RULE13] Pop returns the byte at the pointer
			next_rspData = dataMem[stack_top_pointer];
		end else if (isRead && isStack && !isBit) begin
			next_rspData = stack_top_pointer;
		end else if (isRead && ramGo) begin
			next_rspData = isBit ? bitByte(ramByte, reqBitPos) : ramByte;
		end
	end

	// Answer to the core
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rspValid <= 1'b0;
			rspData <= '0;
			rspReserved <= 1'b0;
			rspRefused <= 1'b0;
		end else if (state == spsd_pkg::ST_CTL_READ) begin
			rspValid <= 1'b1;
			rspData <= ctlBitOp ? bitByte(ctlRdData, ctlBitPos) : ctlRdData;
			rspReserved <= 1'b0;
			rspRefused <= 1'b0;
		end else begin
			rspValid <= take && !(ctlGo && isRead);
			rspData <= next_rspData;
			// [RULE10] Reserved addresses do nothing and are flagged
			rspReserved <= take && reserved && !isPush && !isPop;
			// [RULE9] Bit op on byte-only register is dropped
			rspRefused <= take && (bitRefused ||
				(isStack && isBit)) && !isPush && !isPop;
		end
	end

	// Checks
	a_ptr_reset_value: // [RULE4]
	assert property (@(posedge clock)
		$rose(arst_n) |-> stack_top_pointer == `SPSD_PTR_RESET)
		else $error("Stack pointer not at reset value");

	a_push_moves_up: // [RULE3]
	assert property (@(posedge clock) disable iff (!arst_n)
		isPush |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
		else $error("Push did not increment pointer");

	a_push_lands_data: // [RULE3]
	assert property (@(posedge clock) disable iff (!arst_n)
		isPush |=> dataMem[stack_top_pointer] == $past(reqData))
		else $error("Pushed byte not at new pointer");

	a_pop_moves_down: // [RULE13]
	assert property (@(posedge clock) disable iff (!arst_n)
		isPop |=> rspValid &&
		stack_top_pointer == $past(stack_top_pointer) - 8'h01)
		else $error("Pop did not decrement pointer");

	a_push_pop_pair: // [RULE2]
	assert property (@(posedge clock) disable iff (!arst_n)
		isPush ##1 isPop |=> rspData == $past(reqData, 2))
		else $error("Pop after push returned wrong byte");

	a_upper_routing: // [RULE7]
	assert property (@(posedge clock) disable iff (!arst_n)
		(take && reqDirect && reqAddr[7] && !isStack && !isBit &&
		reqOp == spsd_pkg::OP_WR && !reserved) |=>
		ctlStrobe && ctlWrite && ctlAddr == $past(reqAddr))
		else $error("Direct upper write not routed out");

	a_indirect_stays: // [RULE12]
	assert property (@(posedge clock) disable iff (!arst_n)
		(take && !reqDirect && reqOp != spsd_pkg::OP_PUSH &&
		reqOp != spsd_pkg::OP_POP) |=> !ctlStrobe && rspValid)
		else $error("Indirect access reached registers");

	a_bit_refusal: // [RULE9]
	assert property (@(posedge clock) disable iff (!arst_n)
		(take && bitRefused) |=> rspRefused && !ctlStrobe)
		else $error("Byte-only register took a bit op");

	a_bit_allowed: // [RULE8]
	assert property (@(posedge clock) disable iff (!arst_n)
		(take && isBit && toCtl && !reserved &&
		reqAddr[2:0] == 3'h0) |=> ctlStrobe && ctlBitOp)
		else $error("Bit op refused on bit-capable register");

	a_reserved_quiet: // [RULE10]
	assert property (@(posedge clock) disable iff (!arst_n)
		(take && reserved && !isPush && !isPop) |=>
		rspReserved && !ctlStrobe && rspData == 8'h00)
		else $error("Reserved address had an effect");

	a_ctl_read_time:
	assert property (@(posedge clock) disable iff (!arst_n)
		(ctlGo && isRead) |=> busy && !rspValid ##1 rspValid && !busy)
		else $error("Register read answer mistimed");
endmodule

/* shared/spsd_cfg.svh */
// Constants for the stack pointer and control register decode block
//
// Function
// [RULE1] Stack may sit anywhere in 256-byte data memory, placed by pointer.
// [RULE2] Stack pointer at 0x81 holds address of last written stack byte.
// [RULE3] Push writes pointer plus one first, then increments the pointer.
// [RULE4] Reset loads pointer with 0x07; first push lands at 0x08.
// [RULE5] Software moves the stack off used banks when several banks are used.
// [RULE6] Stack depth may reach all 256 bytes with no smaller limit.
// [RULE7] Direct accesses to 0x80 through 0xFF go to control registers.
// [RULE8] Control registers with low nibble 0x0 or 0x8 accept bit accesses.
// [RULE9] Other control registers take byte accesses only; bit ops refused.
// [RULE10] Unassigned control register addresses are reserved, no function.
// [RULE11] Core must not access unassigned control register addresses.
// [RULE12] Indirect accesses above 0x7F reach upper data RAM, not registers.
// [RULE13] Pop reads byte at pointer, then decrements the pointer.
`ifndef SPSD_CFG_SVH
`define SPSD_CFG_SVH

`define SPSD_DATA_W 8
`define SPSD_MEM_DEPTH 256
`define SPSD_PTR_RESET 8'h07
`define SPSD_PTR_ADDR 8'h81
`define SPSD_PTR_STEP 8'h01
`define SPSD_BIT_NIB_A 4'h0
`define SPSD_BIT_NIB_B 4'h8
`define SPSD_BYTE_ZERO 8'h00
// One bit per address 0x80..0xFF, set where a register is assigned
`define SPSD_CTL_MAP 128'hff5fff577f733d7f7dcf07ffff3fff8f

`endif

/* shared/spsd_pkg.sv */
// Types shared by the stack pointer and control register decode block
package spsd_pkg;
	typedef enum logic [2:0] {
		OP_RD = 3'h0,
		OP_WR = 3'h1,
		OP_BIT_RD = 3'h2,
		OP_BIT_WR = 3'h3,
		OP_PUSH = 3'h4,
		OP_POP = 3'h5
	} spsd_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CTL_READ = 2'b01
	} spsd_state_t;
endpackage

/* test/spsd_periph_model.sv */
// Peripheral register space model on the far side of the decode block
`timescale 1ns/1ps
module spsd_periph_model (
	input wire logic clock,
	input wire logic ctlStrobe,
	input wire logic ctlWrite,
	input wire logic ctlBitOp,
	input wire logic [7:0] ctlAddr,
	input wire logic [2:0] ctlBitPos,
	input wire logic [7:0] ctlWrData,
	output logic [7:0] ctlRdData
);
	logic [7:0] regs [128];
	initial begin
		foreach (regs[i]) regs[i] = 8'h00;
	end
	always @(posedge clock) begin
		if (ctlStrobe && ctlWrite && ctlBitOp) begin
			regs[ctlAddr[6:0]][ctlBitPos] <= ctlWrData[0];
		end else if (ctlStrobe && ctlWrite) begin
			regs[ctlAddr[6:0]] <= ctlWrData;
		end
	end
	// Outside a read cycle the bus shows the inverse, not stale data
	always_comb begin
		if (ctlStrobe && !ctlWrite) ctlRdData = regs[ctlAddr[6:0]];
		else ctlRdData = ~regs[ctlAddr[6:0]];
	end
endmodule

/* test/stack_pointer_and_sfr_decode_test.sv */
// Scenario testbench for the stack pointer and register decode block
`timescale 1ns/1ps
module stack_pointer_and_sfr_decode_test;
	logic clock = 0, arst_n = 0, reqValid = 0, reqDirect = 0, reqBitVal = 0;
	spsd_pkg::spsd_op_t reqOp = spsd_pkg::OP_RD;
	logic [7:0] reqAddr = 0, reqData = 0, ctlRdData, rspData, ctlAddr;
	logic [7:0] ctlWrData, ptr, rd;
	logic [2:0] reqBitPos = 0, ctlBitPos;
	logic busy, rspValid, rspReserved, rspRefused, ctlStrobe, ctlWrite;
	logic ctlBitOp, rsv, rfs;
	int n_fail = 0, checked = 0, cycles = 0, nStrb = 0;
	always #5 clock = ~clock;
	spsd_top uut (.clock(clock), .arst_n(arst_n), .reqValid(reqValid),
		.reqOp(reqOp), .reqDirect(reqDirect), .reqAddr(reqAddr),
		.reqBitPos(reqBitPos), .reqData(reqData), .reqBitVal(reqBitVal),
		.ctlRdData(ctlRdData), .busy(busy), .rspValid(rspValid),
		.rspData(rspData), .rspReserved(rspReserved),
		.rspRefused(rspRefused), .ctlStrobe(ctlStrobe), .ctlWrite(ctlWrite),
		.ctlBitOp(ctlBitOp), .ctlAddr(ctlAddr), .ctlBitPos(ctlBitPos),
		.ctlWrData(ctlWrData), .stack_top_pointer(ptr));
	spsd_periph_model peri (.clock(clock), .ctlStrobe(ctlStrobe),
		.ctlWrite(ctlWrite), .ctlBitOp(ctlBitOp), .ctlAddr(ctlAddr),
		.ctlBitPos(ctlBitPos), .ctlWrData(ctlWrData), .ctlRdData(ctlRdData));
	always @(posedge clock) begin
		if (ctlStrobe === 1'b1) nStrb++;
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic req(input spsd_pkg::spsd_op_t op, input logic dir,
		input logic [7:0] a, input logic [7:0] d, input logic [2:0] bp);
		int n;
		@(posedge clock);
		#1 reqValid = 1;
		reqOp = op;
		reqDirect = dir;
		reqAddr = a;
		reqData = d;
		reqBitVal = d[0];
		reqBitPos = bp;
		@(posedge clock);
		#1 reqValid = 0;
		n = 0;
		while (rspValid !== 1'b1 && n < 4) begin
			@(posedge clock);
			#1 n++;
		end
		if (n == 4) chk(8'h00, 8'h01);
		rd = rspData;
		rsv = rspReserved;
		rfs = rspRefused;
	endtask
	task automatic t_stack();
		chk(ptr, 8'h07);
		req(spsd_pkg::OP_PUSH, 0, 8'h00, 8'ha5, 0);
		chk(ptr, 8'h08);
		req(spsd_pkg::OP_RD, 0, 8'h08, 8'h00, 0);
		chk(rd, 8'ha5);
		req(spsd_pkg::OP_PUSH, 0, 8'h00, 8'h5a, 0);
		req(spsd_pkg::OP_POP, 0, 8'h00, 8'h00, 0);
		chk(rd, 8'h5a);
		chk(ptr, 8'h08);
		$display("stack test done");
	endtask
	task automatic t_wrap();
		// Software places the pointer at 0xFE so the second push wraps to 0x00
		req(spsd_pkg::OP_WR, 1, 8'h81, 8'hfe, 0);
		chk(ptr, 8'hfe);
		req(spsd_pkg::OP_RD, 1, 8'h81, 8'h00, 0);
		chk(rd, 8'hfe);
		req(spsd_pkg::OP_PUSH, 0, 8'h00, 8'h11, 0);
		req(spsd_pkg::OP_PUSH, 0, 8'h00, 8'h22, 0);
		chk(ptr, 8'h00);
		req(spsd_pkg::OP_RD, 0, 8'hff, 8'h00, 0);
		chk(rd, 8'h11);
		req(spsd_pkg::OP_POP, 0, 8'h00, 8'h00, 0);
		chk(rd, 8'h22);
		chk(ptr, 8'hff);
		$display("wrap test done");
	endtask
	task automatic t_space();
		int s;
		s = nStrb;
		req(spsd_pkg::OP_WR, 1, 8'h90, 8'h3c, 0);
		// The strobe is counted at the edge after the answer
		@(posedge clock);
		#1 chk(8'(nStrb - s), 8'h01);
		req(spsd_pkg::OP_WR, 0, 8'h90, 8'h77, 0);
		req(spsd_pkg::OP_RD, 1, 8'h90, 8'h00, 0);
		chk(rd, 8'h3c);
		req(spsd_pkg::OP_RD, 0, 8'h90, 8'h00, 0);
		chk(rd, 8'h77);
		$display("space test done");
	endtask
	task automatic t_bits();
		req(spsd_pkg::OP_BIT_WR, 1, 8'h88, 8'h01, 3);
		req(spsd_pkg::OP_RD, 1, 8'h88, 8'h00, 0);
		chk(rd, 8'h08);
		req(spsd_pkg::OP_BIT_RD, 1, 8'h88, 8'h00, 3);
		chk(rd, 8'h01);
		req(spsd_pkg::OP_BIT_WR, 1, 8'h89, 8'h01, 2);
		chk({7'h0, rfs}, 8'h01);
		req(spsd_pkg::OP_BIT_WR, 1, 8'h81, 8'h00, 0);
		chk({7'h0, rfs}, 8'h01);
		chk(ptr, 8'hff);
		$display("bit test done");
	endtask
	task automatic t_reserved();
		int s;
		s = nStrb;
		req(spsd_pkg::OP_WR, 1, 8'h84, 8'hff, 0);
		chk({7'h0, rsv}, 8'h01);
		req(spsd_pkg::OP_RD, 1, 8'h84, 8'h00, 0);
		chk(rd, 8'h00);
		@(posedge clock);
		#1 chk(8'(nStrb - s), 8'h00);
		$display("reserved test done");
	endtask
	task automatic t_burst();
		// Push and pop on consecutive edges, then a push while busy
		@(posedge clock);
		#1 reqValid = 1;
		reqOp = spsd_pkg::OP_PUSH;
		reqDirect = 0;
		reqData = 8'h3e;
		@(posedge clock);
		#1 reqOp = spsd_pkg::OP_POP;
		chk(ptr, 8'h00);
		@(posedge clock);
		#1 reqOp = spsd_pkg::OP_RD;
		chk(rspData, 8'h3e);
		chk(ptr, 8'hff);
		reqDirect = 1;
		reqAddr = 8'h90;
		@(posedge clock);
		#1 reqOp = spsd_pkg::OP_PUSH;
		chk({7'h0, busy}, 8'h01);
		@(posedge clock);
		#1 reqValid = 0;
		chk({7'h0, rspValid}, 8'h01);
		chk(rspData, 8'h3c);
		chk(ptr, 8'hff);
		chk({7'h0, busy}, 8'h00);
		$display("burst test done");
	endtask
	initial begin
		repeat (3) @(posedge clock);
		#1 arst_n = 1;
		t_stack();
		t_wrap();
		t_space();
		t_bits();
		t_reserved();
		t_burst();
		wrap_up();
	end
endmodule
